/* File: rtl/sebr_map.svh */
// constants of the serial eeprom select and ready/busy block
`ifndef SEBR_MAP_SVH
`define SEBR_MAP_SVH
`define SEBR_CLK_NS     50
`define SEBR_TWC_NS     2000000
`define SEBR_TWC_CYC    (`SEBR_TWC_NS / `SEBR_CLK_NS)
`define SEBR_GROUP      1
`define SEBR_ADDR_W     6
`define SEBR_DATA_W     16
`define SEBR_CNT_W      24
`define SEBR_JIT_W      8
`define SEBR_LFSR_RST   8'h01
`define SEBR_OP_W       2
`define SEBR_OP_MISC    2'h0
`define SEBR_OP_WRITE   2'h1
`define SEBR_OP_READ    2'h2
`define SEBR_OP_ERASE   2'h3
`define SEBR_MISC_ERASE_WRITE_ENABLE_CMD  2'h3
`define SEBR_MISC_EWDS  2'h0
`define SEBR_ERASE_BIT  1'b1
`endif

/* File: rtl/sebr_pkg.sv */
// types of the serial eeprom select and ready/busy block
package sebr_pkg;
  typedef enum {LK_IDLE, LK_OP, LK_ADDR, LK_DATA} sebr_link_e;
  typedef struct packed {
    logic out;
    logic oe;
  } sebr_pin_s;
endpackage : sebr_pkg

/* File: rtl/sebr_mem.sv */
// storage array with registered read port
`timescale 1ns/100ps
module sebr_mem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  // system
  input  wire logic          clk,
  input  wire logic          rst_b,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] wAddr,
  input  wire logic [DW-1:0] wData,
  // read port
  input  wire logic [AW-1:0] rAddr,
  output logic      [DW-1:0] rData
);
  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[wAddr] <= wData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rData <= '0;
    end else begin
      rData <= mem_q[rAddr];
    end
  end
endmodule : sebr_mem

/* File: rtl/sebr_core.sv */
// serial eeprom command intake, write cycle and ready/busy output
//
// Summary of operation
// - groups 1, 3, 5 start the write on the last data bit
// - groups 2, 4 start the write only when select falls afterwards
// - commands arriving during a write cycle are ignored
// - group 1 after polling needs select low-to-high after the cycle
// - groups 1, 3, 5 accept the next command if select stayed high
// - group 1 refuses the next command if select was raised mid cycle
// - group 1 refuses next command if select toggled, high at end
// - select high during write drives output low, then high at the end
// - groups 1, 2, 3 leave output floating if select rises after the cycle
// - groups 4, 5 drive output high if select rises after the cycle
// - the ready level holds until a start condition or until select falls, then floats
// - a clock rise with select and input high is a start condition
// - write time varies and ends unaligned to the serial clock
// - erase sets ones; erase and write need a prior enable command
`timescale 1ns/100ps
`include "sebr_map.svh"
module sebr_core #(
  parameter int GROUP   = `SEBR_GROUP,
  parameter int ADDR_W  = `SEBR_ADDR_W,
  parameter int DATA_W  = `SEBR_DATA_W,
  parameter int TWC_CYC = `SEBR_TWC_CYC
) (
  // system
  input  wire logic               clk,
  input  wire logic               rst_b,
  // serial link
  input  wire logic               sclk,
  input  wire logic               chipSel,
  input  wire logic               serialIn,
  output sebr_pkg::sebr_pin_s     serialOut,
  // array view
  input  wire logic [ADDR_W-1:0]  peekAddr,
  output logic      [DATA_W-1:0]  peekData,
  // status
  output logic                    writeBusy
);
  import sebr_pkg::*;

  localparam int CW = 5;
  localparam bit G135 = (GROUP == 1) || (GROUP == 3) || (GROUP == 5);
  localparam bit G45  = (GROUP == 4) || (GROUP == 5);
  localparam bit G1   = (GROUP == 1);

  if (GROUP < 1 || GROUP > 5 || ADDR_W < 2 || ADDR_W > DATA_W || DATA_W > 32 ||
      TWC_CYC < 1 || TWC_CYC + 256 >= 2**`SEBR_CNT_W) begin : g_badParam
    $error("sebr_core: unsupported parameters");
  end
  // ********************************************************
  // link side, clocked by the serial clock
  // ********************************************************
  logic                 linkRst_b;
  sebr_link_e           lst_q, lst_d;
  logic [CW-1:0]        bit_q, bit_d;
  logic [DATA_W-1:0]    sh_q, sh_d;
  logic [`SEBR_OP_W-1:0] op_q, op_d;
  logic [ADDR_W-1:0]    adr_q, adr_d;
  logic [`SEBR_OP_W-1:0] cOp_q, cOp_d;
  logic [ADDR_W-1:0]    cAdr_q, cAdr_d;
  logic [DATA_W-1:0]    cDat_q, cDat_d;
  logic                 cTgl_q, cTgl_d;
  logic                 sTgl_q, sTgl_d;
  logic                 fire;
  logic                 startSeen;

  // deselect clears a half-shifted frame
  assign linkRst_b = rst_b & chipSel;

  always_comb begin
    lst_d     = lst_q;
    bit_d     = bit_q;
    sh_d      = {sh_q[DATA_W-2:0], serialIn};
    op_d      = op_q;
    adr_d     = adr_q;
    fire      = 1'b0;
    startSeen = 1'b0;
    unique case (lst_q)
      LK_IDLE: begin
        if (serialIn) begin
          startSeen = 1'b1;
          lst_d     = LK_OP;
          bit_d     = '0;
        end
      end
      LK_OP: begin
        op_d = {op_q[0], serialIn};
        if (bit_q == CW'(1)) begin
          lst_d = LK_ADDR;
          bit_d = '0;
        end else begin
          bit_d = bit_q + CW'(1);
        end
      end
      LK_ADDR: begin
        if (bit_q == CW'(ADDR_W - 1)) begin
          adr_d = sh_d[ADDR_W-1:0];
          bit_d = '0;
          if (op_q == `SEBR_OP_WRITE) begin
            lst_d = LK_DATA;
          end else begin
            fire  = 1'b1;
            lst_d = LK_IDLE;
          end
        end else begin
          bit_d = bit_q + CW'(1);
        end
      end
      LK_DATA: begin
        if (bit_q == CW'(DATA_W - 1)) begin
          fire  = 1'b1;
          lst_d = LK_IDLE;
        end else begin
          bit_d = bit_q + CW'(1);
        end
      end
    endcase
  end

  always_comb begin
    cOp_d  = cOp_q;
    cAdr_d = cAdr_q;
    cDat_d = cDat_q;
    cTgl_d = cTgl_q ^ fire;
    sTgl_d = sTgl_q ^ startSeen;
    if (fire) begin
      cOp_d  = op_q;
      cAdr_d = adr_d;
      cDat_d = sh_d;
    end
  end

  always_ff @(posedge sclk or negedge linkRst_b) begin
    if (!linkRst_b) begin
      lst_q <= LK_IDLE;
      bit_q <= '0;
      sh_q  <= '0;
      op_q  <= '0;
      adr_q <= '0;
    end else begin
      lst_q <= lst_d;
      bit_q <= bit_d;
      sh_q  <= sh_d;
      op_q  <= op_d;
      adr_q <= adr_d;
    end
  end

  // held words stay put long after the toggle is seen
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      cOp_q  <= '0;
      cAdr_q <= '0;
      cDat_q <= '0;
      cTgl_q <= 1'b0;
      sTgl_q <= 1'b0;
    end else begin
      cOp_q  <= cOp_d;
      cAdr_q <= cAdr_d;
      cDat_q <= cDat_d;
      cTgl_q <= cTgl_d;
      sTgl_q <= sTgl_d;
    end
  end
  // ********************************************************
  // crossings into the system clock
  // ********************************************************
  logic [2:0] csS_q, cmS_q, stS_q;
  logic       csLvl_q, csLvl_d;
  logic       cmdEv, startEv, csRise;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      csS_q <= '0;
      cmS_q <= '0;
      stS_q <= '0;
    end else begin
      csS_q <= {csS_q[1:0], chipSel};
      cmS_q <= {cmS_q[1:0], cTgl_q};
      stS_q <= {stS_q[1:0], sTgl_q};
    end
  end

  always_comb begin
    csLvl_d = (csS_q[1] == csS_q[2]) ? csS_q[2] : csLvl_q;
    cmdEv   = cmS_q[1] ^ cmS_q[2];
    startEv = stS_q[1] ^ stS_q[2];
    csRise  = csLvl_d & ~csLvl_q;
  end
  // ********************************************************
  // write cycle and ready/busy
  // ********************************************************
  logic                   busy_q, busy_d;
  logic [`SEBR_CNT_W-1:0] cnt_q, cnt_d;
  logic [`SEBR_JIT_W-1:0] lfsr_q, lfsr_d;
  logic                   pend_q, pend_d;
  logic                   en_q, en_d;
  logic                   lock_q, lock_d;
  logic                   low_q, low_d;
  logic                   rdy_q, rdy_d;
  logic                   post_q, post_d;
  logic [ADDR_W-1:0]      wAdr_q, wAdr_d;
  logic [DATA_W-1:0]      wDat_q, wDat_d;
  sebr_pin_s              so_q, so_d;
  logic                   take, isWr, goNow, cycEnd;
  always_comb begin
    take   = cmdEv && !busy_q && !pend_q && !lock_q;
    isWr   = take && en_q && (cOp_q == `SEBR_OP_WRITE || cOp_q == `SEBR_OP_ERASE);
    goNow  = G135 ? isWr : (pend_q && !csLvl_d);
    cycEnd = busy_q && (cnt_q == '0);
    lfsr_d = {lfsr_q[`SEBR_JIT_W-2:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    en_d   = en_q;
    if (take && cOp_q == `SEBR_OP_MISC) begin
      if (cAdr_q[ADDR_W-1 -: 2] == `SEBR_MISC_ERASE_WRITE_ENABLE_CMD) begin
        en_d = 1'b1;
      end else if (cAdr_q[ADDR_W-1 -: 2] == `SEBR_MISC_EWDS) begin
        en_d = 1'b0;
      end
    end
    wAdr_d = isWr ? cAdr_q : wAdr_q;
    wDat_d = wDat_q;
    if (isWr) begin
      wDat_d = (cOp_q == `SEBR_OP_ERASE) ? {DATA_W{`SEBR_ERASE_BIT}} : cDat_q;
    end
    pend_d = (!G135 && isWr) || (pend_q && !goNow);
    busy_d = busy_q;
    cnt_d  = cnt_q;
    if (goNow) begin
      busy_d = 1'b1;
      cnt_d  = `SEBR_CNT_W'(TWC_CYC) + `SEBR_CNT_W'(lfsr_q);
    end else if (cycEnd) begin
      busy_d = 1'b0;
    end else if (busy_q) begin
      cnt_d = cnt_q - `SEBR_CNT_W'(1);
    end
    low_d  = goNow ? 1'b0 : (low_q || (busy_q && !csLvl_q));
    lock_d = lock_q;
    if (G1 && cycEnd && (low_q || !csLvl_q)) begin
      lock_d = 1'b1;
    end else if (csRise && !busy_q) begin
      lock_d = 1'b0;
    end
    rdy_d  = (cycEnd && csLvl_q) || (rdy_q && csLvl_q && !startEv);
    post_d = cycEnd || (post_q && !startEv);
    so_d.oe  = csLvl_q && (busy_q || rdy_q || (G45 && post_q));
    so_d.out = !busy_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      csLvl_q <= 1'b0;
      busy_q  <= 1'b0;
      cnt_q   <= '0;
      lfsr_q  <= `SEBR_LFSR_RST;
      pend_q  <= 1'b0;
      en_q    <= 1'b0;
      lock_q  <= 1'b0;
      low_q   <= 1'b0;
      rdy_q   <= 1'b0;
      post_q  <= 1'b0;
      wAdr_q  <= '0;
      wDat_q  <= '0;
      so_q    <= '0;
    end else begin
      csLvl_q <= csLvl_d;
      busy_q  <= busy_d;
      cnt_q   <= cnt_d;
      lfsr_q  <= lfsr_d;
      pend_q  <= pend_d;
      en_q    <= en_d;
      lock_q  <= lock_d;
      low_q   <= low_d;
      rdy_q   <= rdy_d;
      post_q  <= post_d;
      wAdr_q  <= wAdr_d;
      wDat_q  <= wDat_d;
      so_q    <= so_d;
    end
  end

  assign serialOut = so_q;
  assign writeBusy = busy_q;
  // array commits when the cycle ends
  sebr_mem #(
    .AW (ADDR_W),
    .DW (DATA_W)
  ) u_mem (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (cycEnd),
    .wAddr (wAdr_q),
    .wData (wDat_q),
    .rAddr (peekAddr),
    .rData (peekData)
  );
  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_busyHigh;
    busy_q && csLvl_q;
  endsequence
  sequence s_endHigh;
    cycEnd && csLvl_q ##1 csLvl_q;
  endsequence
  property p_busyLow;
    s_busyHigh |=> !serialOut.out && serialOut.oe;
  endproperty
  a_busyLow: assert property (p_busyLow) else $error("busy not shown low");
  property p_readyHigh;
    s_endHigh |=> serialOut.out && serialOut.oe;
  endproperty
  a_readyHigh: assert property (p_readyHigh) else $error("ready not shown high");
  property p_ignore;
    cmdEv && busy_q |=> $stable(en_q) && !$rose(pend_q);
  endproperty
  a_ignore: assert property (p_ignore) else $error("command taken while busy");
  property p_startNow;
    G135 && isWr |=> busy_q && cnt_q >= `SEBR_CNT_W'(TWC_CYC);
  endproperty
  a_startNow: assert property (p_startNow) else $error("write not started at last bit");
  property p_waitFall;
    !G135 && pend_q && csLvl_d |=> !$rose(busy_q);
  endproperty
  a_waitFall: assert property (p_waitFall) else $error("write started without select low");
  property p_lock;
    G1 && cycEnd && (low_q || !csLvl_q) |=> lock_q;
  endproperty
  a_lock: assert property (p_lock) else $error("next command not refused");
  property p_noLock;
    !G1 |-> !lock_q;
  endproperty
  a_noLock: assert property (p_noLock) else $error("refusal outside group one");
  property p_keepHigh;
    G1 && cycEnd && !low_q && csLvl_q |=> !lock_q;
  endproperty
  a_keepHigh: assert property (p_keepHigh) else $error("select held high yet refused");
  property p_float;
    !G45 && csRise && !busy_q && !cycEnd && !rdy_q |=> ##1 !serialOut.oe;
  endproperty
  a_float: assert property (p_float) else $error("output driven after late select");
  property p_lateReady;
    G45 && csRise && post_q && !busy_q && !startEv |=> ##1 serialOut.oe && serialOut.out;
  endproperty
  a_lateReady: assert property (p_lateReady) else $error("late ready not driven");
  property p_release;
    startEv && !busy_q && !cycEnd |=> !rdy_q && !post_q ##1 !serialOut.oe;
  endproperty
  a_release: assert property (p_release) else $error("ready kept after start");
  property p_enable;
    $rose(busy_q) |-> $past(en_q, 1) || pend_q == 1'b0 && en_q;
  endproperty
  a_enable: assert property (p_enable) else $error("write without enable");
  property p_start;
    @(posedge sclk) disable iff (!linkRst_b) lst_q == LK_IDLE && serialIn |=> lst_q == LK_OP;
  endproperty
  a_start: assert property (p_start) else $error("start condition missed");
endmodule : sebr_core

/* File: sim/sebr_host.sv */
// host model driving select, serial clock and serial input
`timescale 1ns/100ps
module sebr_host (
  // serial link
  output logic sclk,
  output logic chipSel,
  output logic serialIn
);
  initial begin
    sclk     = 1'b0;
    chipSel  = 1'b0;
    serialIn = 1'b0;
  end
  // ************************************
  // select and frame tasks
  // ************************************
  // select moves well clear of any clock edge
  task automatic setSel(input logic v);
    #37;
    chipSel = v;
  endtask : setSel
  // msb first, clock low and still outside frames
  task automatic frame(input logic [24:0] bits, input int n);
    int i;
    if (!chipSel)
      setSel(1'b1);
    for (i = n - 1; i >= 0; i--) begin
      serialIn = bits[i];
      #62.5;
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
    serialIn = 1'b0;
  endtask : frame
endmodule : sebr_host

/* File: sim/tb_sebr_core.sv */
// bench for the select and ready/busy block, all five groups side by side
`timescale 1ns/100ps
module tb_sebr_core;
  import sebr_pkg::*;
  typedef struct packed {
    logic [24:0] bits;
    logic [5:0]  addr;
    logic [15:0] data;
  } sebr_row_s;
  localparam logic [24:0] ENA = 25'h130;
  localparam logic [24:0] DIS = 25'h100;
  logic        clk;
  logic        rst_b;
  logic        sclk;
  logic        chipSel;
  logic        serialIn;
  logic [5:0]  peekAddr;
  logic [4:0]  busy;
  logic [4:0]  soOut;
  logic [4:0]  soOe;
  logic [15:0] peek [5];
  int          numErrors;
  int          samplesChecked;
  int          ticks;
  sebr_row_s   rows [4] = '{'{{1'b1, 2'b01, 6'h05, 16'ha5c3}, 6'h05, 16'ha5c3},
                            '{{1'b1, 2'b01, 6'h3f, 16'h0001}, 6'h3f, 16'h0001},
                            '{{16'h0, 1'b1, 2'b11, 6'h05}, 6'h05, 16'hffff},
                            '{{1'b1, 2'b01, 6'h00, 16'h8000}, 6'h00, 16'h8000}};
  // ************************************
  // design and host
  // ************************************
  sebr_host sebr_host_i (.sclk(sclk), .chipSel(chipSel), .serialIn(serialIn));
  for (genvar g = 0; g < 5; g++) begin : grp
    sebr_pin_s so;
    sebr_core #(.GROUP(g + 1), .TWC_CYC(60)) sebr_core_i (
      .clk(clk), .rst_b(rst_b), .sclk(sclk), .chipSel(chipSel), .serialIn(serialIn),
      .serialOut(so), .peekAddr(peekAddr), .peekData(peek[g]), .writeBusy(busy[g]));
    assign soOut[g] = so.out;
    assign soOe[g]  = so.oe;
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      numErrors++;
      printVerdict();
    end
  end
  // ************************************
  // helpers
  // ************************************
  function automatic logic [24:0] wr(input logic [5:0] a, input logic [15:0] d);
    return {1'b1, 2'b01, a, d};
  endfunction : wr
  function automatic logic [24:0] er(input logic [5:0] a);
    return {16'h0, 1'b1, 2'b11, a};
  endfunction : er
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      numErrors++;
      $display("FAIL %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // poll busy under a bound, never a fixed wait
  task automatic idle();
    int i;
    for (i = 0; i < 400 && busy !== 5'h00; i++)
      @(negedge clk);
    check("busy", 16'(busy), 16'h0000);
    cyc(6);
  endtask : idle
  // whole frame, optional select drop, then settle
  task automatic go(input logic [24:0] b, input logic low);
    sebr_host_i.frame(b, b[24] ? 25 : 9);
    if (low)
      sebr_host_i.setSel(1'b0);
    cyc(12);
  endtask : go
  task automatic peekAll(input logic [5:0] a, input logic [15:0] d, input logic [4:0] m);
    int g;
    @(negedge clk);
    peekAddr = a;
    cyc(2);
    for (g = 0; g < 5; g++)
      if (m[g])
        check("data", peek[g], d);
  endtask : peekAll
  task automatic printVerdict();
    if (numErrors == 0 && samplesChecked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : printVerdict
  // ************************************
  // sequence
  // ************************************
  initial begin
    rst_b          = 1'b0;
    peekAddr       = 6'h00;
    numErrors      = 0;
    samplesChecked = 0;
    ticks          = 0;
    cyc(10);
    check("busy", 16'(busy), 16'h0000);
    check("oe", 16'(soOe), 16'h0000);
    rst_b = 1'b1;
    cyc(4);
    go(ENA, 1'b1);
    check("busy", 16'(busy), 16'h0000);
    foreach (rows[r]) begin
      go(rows[r].bits, 1'b1);
      check("busy", 16'(busy), 16'h001f);
      idle();
      peekAll(rows[r].addr, rows[r].data, 5'h1f);
    end
    // writes without enable
    go(DIS, 1'b1);
    go(wr(6'h05, 16'h1234), 1'b1);
    check("busy", 16'(busy), 16'h0000);
    peekAll(6'h05, 16'hffff, 5'h1f);
    go(ENA, 1'b1);
    // select held high through the write
    go(wr(6'h10, 16'h5a5a), 1'b0);
    check("busy", 16'(busy), 16'h0015);
    check("oe", 16'(soOe & 5'h15), 16'h0015);
    check("out", 16'(soOut & 5'h15), 16'h0000);
    go(er(6'h10), 1'b0);
    idle();
    check("out", 16'(soOut & soOe & 5'h15), 16'h0015);
    go(ENA, 1'b0);
    check("oe", 16'(soOe & 5'h15), 16'h0000);
    go(er(6'h11), 1'b0);
    check("busy", 16'(busy), 16'h0015);
    sebr_host_i.setSel(1'b0);
    cyc(12);
    check("busy", 16'(busy), 16'h001f);
    idle();
    peekAll(6'h10, 16'h5a5a, 5'h1f);
    peekAll(6'h11, 16'hffff, 5'h15);
    // select dropped, then raised mid cycle
    go(wr(6'h20, 16'h0f0f), 1'b1);
    sebr_host_i.setSel(1'b1);
    cyc(8);
    check("oe", 16'(soOe), 16'h001f);
    check("out", 16'(soOut), 16'h0000);
    idle();
    check("out", 16'(soOut & soOe), 16'h001f);
    go(wr(6'h21, 16'h00ff), 1'b1);
    check("busy", 16'(busy), 16'h001e);
    idle();
    go(wr(6'h21, 16'h00ff), 1'b1);
    check("busy", 16'(busy), 16'h001f);
    idle();
    peekAll(6'h21, 16'h00ff, 5'h1f);
    // select raised after the cycle ended
    sebr_host_i.setSel(1'b1);
    cyc(8);
    check("oe", 16'(soOe), 16'h0018);
    check("out", 16'(soOut & soOe), 16'h0018);
    go(ENA, 1'b0);
    check("oe", 16'(soOe), 16'h0000);
    // reset in mid cycle clears busy, output and enable
    go(wr(6'h30, 16'h3c3c), 1'b0);
    check("busy", 16'(busy), 16'h0015);
    rst_b = 1'b0;
    cyc(2);
    check("busy", 16'(busy), 16'h0000);
    check("oe", 16'(soOe), 16'h0000);
    rst_b = 1'b1;
    cyc(2);
    check("busy", 16'(busy), 16'h0000);
    check("oe", 16'(soOe), 16'h0000);
    sebr_host_i.setSel(1'b0);
    cyc(6);
    go(wr(6'h30, 16'h3c3c), 1'b1);
    check("busy", 16'(busy), 16'h0000);
    printVerdict();
  end
endmodule : tb_sebr_core
